// File: design/pivc_defines.svh
// Constants of the periodic interrupt and vector controller.
// Assumes nothing; included by the package and the design modules.
`ifndef PIVC_DEFINES_SVH
`define PIVC_DEFINES_SVH

`define PIVC_CLK_HZ        10000000
`define PIVC_SLOW_HZ       32768
`define PIVC_SLOW_DIV      (`PIVC_CLK_HZ / `PIVC_SLOW_HZ)
`define PIVC_CHAIN_W       14
`define PIVC_NSRC          8
`define PIVC_PC_W          16
`define PIVC_STACK_DEPTH   4
`define PIVC_SP_W          3

`define PIVC_IDX_FLAG      8'h0D
`define PIVC_IDX_ROUTE     8'h0E
`define PIVC_IDX_RATE      8'h0F
`define PIVC_IDX_MASK      8'h10

`define PIVC_RATE_RST      8'h43
`define PIVC_ROUTE_RST     8'h00
`define PIVC_MASK_RST      8'h00
`define PIVC_FT_LSB        0
`define PIVC_ST_LSB        3
`define PIVC_EXT_EDGE_BIT  6
`define PIVC_FT_TAPS       32'h0123_468A
`define PIVC_ST_TAP_TOP    4'hD

`define PIVC_VEC_BASE      16'h07E0
`define PIVC_SRC_T2        0
`define PIVC_SRC_FT        3
`define PIVC_SRC_EXT       5

`endif

// File: design/pivc_pkg.sv
// Types shared by the periodic interrupt and vector controller.
// Assumes pivc_defines.svh on the include path.
`include "pivc_defines.svh"
`default_nettype none
package pivc_pkg;
	typedef enum logic [1:0] {
		PIVC_IDLE  = 2'b01,
		PIVC_SERVE = 2'b10
	} pivc_state_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] idx;
	} pivc_pick_t;

	typedef struct packed {
		pivc_state_t                                      st;
		logic [7:0]                                       cfg;
		logic [7:0]                                       flags;
		logic [7:0]                                       route;
		logic [7:0]                                       mask;
		logic                                             ext_s1;
		logic                                             ext_s2;
		logic                                             ext_prev;
		logic                                             ft_prev;
		logic                                             st_prev;
		logic                                             nmi_pend;
		logic [2:0]                                       nmi_idx;
		logic                                             irq_line;
		logic [`PIVC_SP_W-1:0]                            sp;
		logic [`PIVC_STACK_DEPTH-1:0][`PIVC_PC_W-1:0]     call_stack;
		logic [`PIVC_PC_W-1:0]                            vec;
		logic                                             vec_v;
		logic [`PIVC_PC_W-1:0]                            res_pc;
		logic                                             res_v;
		logic [31:0]                                      prdata;
		logic                                             pready;
		logic                                             pslverr;
	} pivc_regs_t;

	typedef struct packed {
		logic [15:0]               cnt;
		logic [`PIVC_CHAIN_W-1:0]  chain;
	} pivc_div_t;
endpackage
`default_nettype wire

// File: design/pivc_divider.sv
// Slow-clock divider chain: a tick every DIV clocks advances the chain.
// Assumes one clock; free-running from reset.
`include "pivc_defines.svh"
`default_nettype none
module pivc_divider #(
	parameter int unsigned DIV = `PIVC_SLOW_DIV
) (
	input  wire logic                      clk_in,
	input  wire logic                      rst_n_in,
	output logic [`PIVC_CHAIN_W-1:0]       chain_out
);
	pivc_pkg::pivc_div_t r;
	pivc_pkg::pivc_div_t s;

	always_comb begin
		s = r;
		if (r.cnt == 16'(DIV - 1)) begin
			s.cnt   = 16'h0000;
			s.chain = r.chain + 1'b1;
		end else begin
			s.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
		end else begin
			r <= s;
		end
	end

	assign chain_out = r.chain;
endmodule
`default_nettype wire

// File: design/pivc_prio_enc.sv
// Fixed priority picker: bit 0 wins, highest bit loses.
// Purely combinational.
`include "pivc_defines.svh"
`default_nettype none
module pivc_prio_enc (
	input  wire logic [`PIVC_NSRC-1:0] req_in,
	output pivc_pkg::pivc_pick_t       pick_out
);
	always_comb begin
		pick_out = '0;
		for (int i = `PIVC_NSRC - 1; i >= 0; i--) begin
			if (req_in[i]) begin
				pick_out.valid = 1'b1;
				pick_out.idx   = 3'(i);
			end
		end
	end
endmodule
`default_nettype wire

// File: design/pivc_top.sv
// Periodic interrupt rates, pin edge select, flags, routing and vectoring.
// Assumes an APB master on clk_in and a core that acks and returns.
// Overview of operation
// - Rate field bits 2..0 pick fast tap: 010=6,011=4,100=3,101=2,110=1,111=0.
// - Fast field code 000 picks tap 10, code 001 picks tap 8.
// - Fast field resets to code 011, tap 4.
// - Slow field bits 5..3: codes 000..111 pick taps 13 down to 6.
// - Slow field resets to code 000, tap 13.
// - Bit 6 picks pin edge: one rising, zero falling; resets rising.
// - On accept, push program counter, then hand out the source vector.
// - Vectors two bytes apart from 7E0 for source 0 to 7EE.
// - Fixed priority: source 0 highest, source 7 lowest.
// - IRQ is level sensed; a held request is served after the handler.
// - Several pending IRQ requests: highest priority served first.
// - NMI is edge sensed; only highest simultaneous edge kept.
// - On return, pop saved program counter and resume.
// - Per-source route bit: one NMI, zero IRQ; resets to IRQ.
// - Flags read back; writing zero to a bit clears it.
//
// The APB interface to the registers was left to the implementer.
`include "pivc_defines.svh"
`default_nettype none
module pivc_top #(
	parameter int unsigned SLOW_DIV = `PIVC_SLOW_DIV
) (
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   psel_in,
	input  wire logic                   penable_in,
	input  wire logic                   pwrite_in,
	input  wire logic [11:0]            paddr_in,
	input  wire logic [31:0]            pwdata_in,
	output logic [31:0]                 prdata_out,
	output logic                        pready_out,
	output logic                        pslverr_out,
	input  wire logic                   timer2_event_in,
	input  wire logic                   timer1_event_in,
	input  wire logic                   timer0_event_in,
	input  wire logic                   adc_event_in,
	input  wire logic                   key_scan_interrupt_in,
	input  wire logic                   pin_edge_interrupt_in,
	input  wire logic                   core_ack_in,
	input  wire logic [`PIVC_PC_W-1:0]  core_pc_in,
	input  wire logic                   core_rti_in,
	output logic                        irq_out,
	output logic                        nmi_out,
	output logic [`PIVC_PC_W-1:0]       vector_out,
	output logic                        vector_valid_out,
	output logic [`PIVC_PC_W-1:0]       resume_pc_out,
	output logic                        resume_valid_out
);
	// Nibble n holds the tap number for fast code n; a literal cannot be sliced
	localparam logic [31:0] FT_TAPS = `PIVC_FT_TAPS;

	pivc_pkg::pivc_regs_t r;
	pivc_pkg::pivc_regs_t s;

	logic [`PIVC_CHAIN_W-1:0] chain;
	logic [`PIVC_NSRC-1:0]    irq_req;
	logic [`PIVC_NSRC-1:0]    nmi_new;
	logic [`PIVC_NSRC-1:0]    set_ev;
	pivc_pkg::pivc_pick_t     irq_pick;
	pivc_pkg::pivc_pick_t     nmi_pick;
	logic [3:0]               ft_sel;
	logic [3:0]               st_sel;
	logic                     ft_tap;
	logic                     st_tap;
	logic                     ext_ev;
	logic                     acc;
	logic                     done;
	logic                     hit;
	logic [7:0]               idx;
	logic                     take;

	pivc_divider #(
		.DIV       (SLOW_DIV)
	) u_div (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.chain_out (chain)
	);

	pivc_prio_enc u_irq_pick (
		.req_in    (irq_req),
		.pick_out  (irq_pick)
	);

	pivc_prio_enc u_nmi_pick (
		.req_in    (nmi_new),
		.pick_out  (nmi_pick)
	);

	// Tap numbers from the rate fields
	always_comb begin
		ft_sel = FT_TAPS[{r.cfg[`PIVC_FT_LSB +: 3], 2'b00} +: 4];
		st_sel = `PIVC_ST_TAP_TOP - {1'b0, r.cfg[`PIVC_ST_LSB +: 3]};
		ft_tap = chain[ft_sel];
		st_tap = chain[st_sel];
	end

	// Source events; periodic ones fire on the falling edge of the tap
	always_comb begin
		ext_ev = r.cfg[`PIVC_EXT_EDGE_BIT] ? (r.ext_s2 & ~r.ext_prev) : (~r.ext_s2 & r.ext_prev);
		set_ev = {key_scan_interrupt_in, adc_event_in, ext_ev,
			r.st_prev & ~st_tap, r.ft_prev & ~ft_tap,
			timer0_event_in, timer1_event_in, timer2_event_in};
		nmi_new = set_ev & ~r.flags & r.route;
		irq_req = r.flags & ~r.route & r.mask;
	end

	// APB decode; one wait state so every answer comes from a flop
	always_comb begin
		acc  = psel_in & penable_in;
		done = acc & r.pready;
		idx  = paddr_in[9:2];
		hit  = (paddr_in[11:10] == 2'b00) && (paddr_in[1:0] == 2'b00) &&
			((idx == `PIVC_IDX_FLAG) || (idx == `PIVC_IDX_ROUTE) ||
			(idx == `PIVC_IDX_RATE) || (idx == `PIVC_IDX_MASK));
		take = core_ack_in && (r.sp < `PIVC_SP_W'(`PIVC_STACK_DEPTH)) && (r.nmi_pend || (r.irq_line && irq_pick.valid));
	end

	always_comb begin
		s       = r;
		s.vec_v = 1'b0;
		s.res_v = 1'b0;

		// Pin crosses in by two flops before the edge detector looks at it
		s.ext_s1   = pin_edge_interrupt_in;
		s.ext_s2   = r.ext_s1;
		s.ext_prev = r.ext_s2;
		s.ft_prev  = ft_tap;
		s.st_prev  = st_tap;

		s.pready  = acc & ~r.pready;
		s.pslverr = acc & ~r.pready & ~hit;
		if (acc && !r.pready) begin
			unique case (idx)
				`PIVC_IDX_FLAG:  s.prdata = {24'h00_0000, r.flags};
				`PIVC_IDX_ROUTE: s.prdata = {24'h00_0000, r.route};
				`PIVC_IDX_RATE:  s.prdata = {24'h00_0000, r.cfg};
				`PIVC_IDX_MASK:  s.prdata = {24'h00_0000, r.mask};
				default:         s.prdata = 32'h0000_0000;
			endcase
		end

		// Flag clear by writing zero; a same-cycle event still sets
		if (done && pwrite_in && hit && (idx == `PIVC_IDX_FLAG)) begin
			s.flags = r.flags & pwdata_in[7:0];
		end
		s.flags = s.flags | set_ev;
		if (done && pwrite_in && hit) begin
			if (idx == `PIVC_IDX_ROUTE) begin
				s.route = pwdata_in[7:0];
			end
			if (idx == `PIVC_IDX_RATE) begin
				s.cfg = pwdata_in[7:0];
			end
			if (idx == `PIVC_IDX_MASK) begin
				s.mask = pwdata_in[7:0];
			end
		end

		// Accept: push the interrupted address, then hand out the vector
		if (take) begin
			s.call_stack[r.sp[`PIVC_SP_W-2:0]] = core_pc_in;
			s.sp    = r.sp + 1'b1;
			s.st    = pivc_pkg::PIVC_SERVE;
			s.vec_v = 1'b1;
			if (r.nmi_pend) begin
				s.vec      = `PIVC_VEC_BASE + {12'h000, r.nmi_idx, 1'b0};
				s.nmi_pend = 1'b0;
			end else begin
				s.vec = `PIVC_VEC_BASE + {12'h000, irq_pick.idx, 1'b0};
			end
		end else if (core_rti_in && (r.sp != '0)) begin
			s.res_pc = r.call_stack[3'(r.sp - 1'b1)];
			s.res_v  = 1'b1;
			s.sp     = r.sp - 1'b1;
			if (r.sp == `PIVC_SP_W'(1)) begin
				s.st = pivc_pkg::PIVC_IDLE;
			end
		end

		// Only one simultaneous edge is kept; later ones wait for none
		if (!s.nmi_pend && nmi_pick.valid) begin
			s.nmi_pend = 1'b1;
			s.nmi_idx  = nmi_pick.idx;
		end

		// Level request held off while a handler runs
		s.irq_line = irq_pick.valid && (s.st == pivc_pkg::PIVC_IDLE) && !take;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r       <= '0;
			r.st    <= pivc_pkg::PIVC_IDLE;
			r.cfg   <= `PIVC_RATE_RST;
			r.route <= `PIVC_ROUTE_RST;
			r.mask  <= `PIVC_MASK_RST;
		end else begin
			r <= s;
		end
	end

	assign prdata_out       = r.prdata;
	assign pready_out       = r.pready;
	assign pslverr_out      = r.pslverr;
	assign irq_out          = r.irq_line;
	assign nmi_out          = r.nmi_pend;
	assign vector_out       = r.vec;
	assign vector_valid_out = r.vec_v;
	assign resume_pc_out    = r.res_pc;
	assign resume_valid_out = r.res_v;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	flag_set_wins_a: assert property (timer2_event_in |=> r.flags[`PIVC_SRC_T2])
		else $error("event lost against clear");
	flag_clear_a: assert property (done && pwrite_in && hit && (idx == `PIVC_IDX_FLAG) && !pwdata_in[0] && !timer2_event_in
		|=> !r.flags[`PIVC_SRC_T2])
		else $error("flag not cleared by zero");
	ft_tick_a: assert property (r.ft_prev && !ft_tap |=> r.flags[`PIVC_SRC_FT])
		else $error("fast tick missed");
	ext_edge_a: assert property (r.cfg[`PIVC_EXT_EDGE_BIT] && r.ext_s2 && !r.ext_prev
		|=> r.flags[`PIVC_SRC_EXT])
		else $error("pin edge missed");
	vec_range_a: assert property (vector_valid_out |-> !vector_out[0] && vector_out >= `PIVC_VEC_BASE
		&& vector_out <= `PIVC_VEC_BASE + 16'h000E)
		else $error("vector out of table");
	irq_prio_a: assert property (take && !r.nmi_pend |=> vector_out ==
		`PIVC_VEC_BASE + {12'h000, $past(irq_pick.idx), 1'b0})
		else $error("wrong priority vector");
	push_count_a: assert property (take |=> vector_valid_out && r.sp == $past(r.sp) + 1'b1)
		else $error("push missing");
	pop_pc_a: assert property (core_rti_in && !take && r.sp != '0
		|=> resume_valid_out && resume_pc_out == $past(r.call_stack[3'(r.sp - 1'b1)]))
		else $error("wrong resume address");
	serve_hold_a: assert property (r.st == pivc_pkg::PIVC_SERVE |-> !irq_out)
		else $error("request during handler");
	irq_resume_a: assert property (r.st == pivc_pkg::PIVC_SERVE && s.st == pivc_pkg::PIVC_IDLE
		&& irq_req == $past(irq_req) && irq_req != '0 |-> ##[1:2] irq_out)
		else $error("held request not served");
	nmi_latch_a: assert property (!r.nmi_pend && nmi_pick.valid |=> nmi_out
		&& r.nmi_idx == $past(nmi_pick.idx))
		else $error("nmi edge lost");
endmodule
`default_nettype wire

// File: dv/pivc_core_model.sv
// Behavioural core: takes a vectored interrupt, runs a handler, returns.
// Assumes the controller's clock and reset; en_in lets the bench hold it off.
`default_nettype none
module pivc_core_model (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        en_in,
	input  wire logic [7:0]  hold_in,
	input  wire logic        irq_in,
	input  wire logic        nmi_in,
	input  wire logic        vec_valid_in,
	output logic             ack_out,
	output logic             rti_out,
	output logic [15:0]      pc_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       busy_r;
	logic       run_r;
	logic [7:0] cnt_r;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{ack_out, rti_out, busy_r, run_r, cnt_r} <= '0;
			pc_out <= 16'h1000;
		end else begin
			ack_out <= 1'h0;
			rti_out <= 1'h0;
			if (!busy_r && en_in && (irq_in || nmi_in)) begin
				ack_out <= 1'h1;
				busy_r  <= 1'h1;
			end else if (busy_r && !run_r && vec_valid_in) begin
				run_r <= 1'h1;
				cnt_r <= hold_in;
			end else if (run_r && cnt_r != 8'h00) begin
				// Register save and restore time
				cnt_r <= cnt_r - 8'h01;
			end else if (run_r) begin
				{rti_out, busy_r, run_r} <= 3'h4;
				pc_out <= pc_out + 16'h0102;
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the periodic interrupt and vector controller.
// Assumes the design files compiled first; divider shortened to SLOW_DIV 2.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] A_FLAG  = 12'h034;
	localparam logic [11:0] A_ROUTE = 12'h038;
	localparam logic [11:0] A_RATE  = 12'h03C;
	localparam logic [11:0] A_MASK  = 12'h040;
	logic        clk_in, rst_n_in, psel, penable, pwrite, pin, core_en;
	logic        pready_out, pslverr_out, core_ack, core_rti;
	logic        irq_out, nmi_out, vector_valid_out, resume_valid_out;
	logic [4:0]  ev;
	logic [7:0]  hold;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_out;
	logic [15:0] core_pc, vector_out, resume_pc_out, pushed_pc;
	int          num_errors, checks_done, cyc;
	int          ftap[8] = '{10, 8, 6, 4, 3, 2, 1, 0};

	pivc_top #(.SLOW_DIV(2)) i_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .timer2_event_in(ev[0]), .timer1_event_in(ev[1]), .timer0_event_in(ev[2]),
		.adc_event_in(ev[3]), .key_scan_interrupt_in(ev[4]), .pin_edge_interrupt_in(pin),
		.core_ack_in(core_ack), .core_pc_in(core_pc), .core_rti_in(core_rti), .irq_out(irq_out),
		.nmi_out(nmi_out), .vector_out(vector_out), .vector_valid_out(vector_valid_out),
		.resume_pc_out(resume_pc_out), .resume_valid_out(resume_valid_out));

	pivc_core_model i_core (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .en_in(core_en), .hold_in(hold), .irq_in(irq_out),
		.nmi_in(nmi_out), .vec_valid_in(vector_valid_out), .ack_out(core_ack), .rti_out(core_rti),
		.pc_out(core_pc));

	initial begin
		clk_in = 1'h0;
		forever #50 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		if (core_ack === 1'h1)
			pushed_pc <= core_pc;
	end

	task automatic tally_and_finish;
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 100000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Holds the request until pready is sampled high or 50 clocks pass, no fixed wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
			output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk_in);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge clk_in);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'h1 && n < 50);
		rd = prdata_out;
		er = pslverr_out;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wait_for(input int which, input int lim, output int n);
		logic s;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
			s = (which == 0) ? irq_out : (which == 1) ? vector_valid_out : resume_valid_out;
		end while (s !== 1'h1 && n < lim);
	endtask

	// Extra edge so the registered irq has seen the clear
	task automatic clr_wait(input int lim, output int n);
		logic [31:0] rd;
		logic        er;
		apb(1'h1, A_FLAG, 8'h00, rd, er);
		@(posedge clk_in);
		wait_for(0, lim, n);
	endtask

	task automatic rate_chk(input logic [7:0] cfg, input int b, input int tap);
		int          per, n;
		time         t0;
		logic [31:0] rd;
		logic        er;
		per = 4 << tap;
		apb(1'h1, A_RATE, cfg, rd, er);
		apb(1'h1, A_MASK, 8'h01 << b, rd, er);
		clr_wait(2 * per + 20, n);
		t0 = $time;
		clr_wait(2 * per + 20, n);
		if (per >= 16)
			chk("tap period", 32'(($time - t0) / 100), per);
		else
			chk("tap bound", {31'h0, n <= per}, 32'h0000_0001);
	endtask

	// Synced to a tap 10 fall, so no slower tap may fall for 4096 clocks
	task automatic long_chk(input logic [2:0] code);
		int          n;
		logic [31:0] rd;
		logic        er;
		apb(1'h1, A_RATE, 8'h58, rd, er);
		clr_wait(9000, n);
		apb(1'h1, A_RATE, {2'h1, code, 3'h0}, rd, er);
		clr_wait(3500, n);
		chk("slow tap quiet", n, 3500);
	endtask

	task automatic serve(input int idx, input logic clr);
		int          n;
		logic [31:0] rd;
		logic        er;
		wait_for(1, 200, n);
		chk("vector", {16'h0000, vector_out}, 32'h0000_07E0 + 32'(2 * idx));
		if (clr)
			apb(1'h1, A_FLAG, ~(8'h01 << idx), rd, er);
		wait_for(2, 200, n);
		chk("resume pc", {16'h0000, resume_pc_out}, {16'h0000, pushed_pc});
	endtask

	task automatic t_regs;
		logic [31:0] rd;
		logic        er;
		apb(1'h0, A_RATE, 8'h00, rd, er);
		chk("rate reset", rd, 32'h0000_0043);
		apb(1'h0, A_ROUTE, 8'h00, rd, er);
		chk("route reset", rd, 32'h0000_0000);
		apb(1'h0, A_FLAG, 8'h00, rd, er);
		chk("flag reset", rd & 32'h0000_00E7, 32'h0000_0000);
		apb(1'h1, A_ROUTE, 8'hA5, rd, er);
		apb(1'h0, A_ROUTE, 8'h00, rd, er);
		chk("route rw", rd, 32'h0000_00A5);
		apb(1'h1, A_ROUTE, 8'h00, rd, er);
		apb(1'h0, 12'h044, 8'h00, rd, er);
		chk("unmapped err", {31'h0, er}, 32'h0000_0001);
	endtask

	task automatic t_rates;
		for (int c = 0; c < 8; c++)
			rate_chk({5'h08, c[2:0]}, 3, ftap[c]);
		for (int c = 7; c > 2; c--)
			rate_chk({2'h1, c[2:0], 3'h0}, 4, 13 - c);
		for (int c = 0; c < 3; c++)
			long_chk(c[2:0]);
	endtask

	task automatic pin_step(input logic lvl, input logic [31:0] exp);
		logic [31:0] rd;
		logic        er;
		apb(1'h1, A_FLAG, 8'h00, rd, er);
		pin <= lvl;
		repeat (8) @(posedge clk_in);
		apb(1'h0, A_FLAG, 8'h00, rd, er);
		chk("pin flag", rd & 32'h0000_00E7, exp);
	endtask

	task automatic t_pin;
		logic [31:0] rd;
		logic        er;
		pin_step(1'h1, 32'h0000_0020);
		pin_step(1'h0, 32'h0000_0000);
		apb(1'h1, A_RATE, 8'h03, rd, er);
		pin_step(1'h1, 32'h0000_0000);
		pin_step(1'h0, 32'h0000_0020);
		apb(1'h1, A_RATE, 8'h43, rd, er);
	endtask

	task automatic t_prio;
		int          n;
		int          idx[7] = '{0, 0, 1, 2, 5, 6, 7};
		logic [31:0] rd;
		logic        er;
		hold <= 8'h10;
		apb(1'h1, A_FLAG, 8'h00, rd, er);
		apb(1'h1, A_MASK, 8'hE7, rd, er);
		@(posedge clk_in);
		ev  <= 5'h1F;
		pin <= 1'h1;
		@(posedge clk_in);
		ev <= 5'h00;
		repeat (8) @(posedge clk_in);
		core_en <= 1'h1;
		// First pass leaves the flag set: a held level is served again
		for (int i = 0; i < 7; i++)
			serve(idx[i], i != 0);
		wait_for(0, 40, n);
		chk("irq idle", n, 40);
	endtask

	task automatic t_nmi;
		int          n;
		logic [31:0] rd;
		logic        er;
		hold <= 8'h02;
		apb(1'h1, A_MASK, 8'h00, rd, er);
		apb(1'h1, A_FLAG, 8'h00, rd, er);
		apb(1'h1, A_ROUTE, 8'h42, rd, er);
		@(posedge clk_in);
		ev <= 5'h0A;
		@(posedge clk_in);
		ev <= 5'h00;
		serve(1, 1'h0);
		wait_for(1, 40, n);
		chk("nmi lost", n, 40);
	endtask

	initial begin
		{rst_n_in, psel, penable, pwrite, pin, core_en, ev} = '0;
		paddr  = 12'h000;
		pwdata = 32'h0000_0000;
		hold   = 8'h10;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'h1;
		t_regs();
		t_rates();
		t_pin();
		t_prio();
		t_nmi();
		tally_and_finish();
	end
endmodule
`default_nettype wire
